// [plw_overflow_cmp.sv]
`timescale 1ns/1ps
// Overflow detect: one count step away from 2^exp
module plw_overflow_cmp (
    input  wire logic [plw_pkg::PLW_CNT_W-1:0] count,
    input  wire logic [4:0]                    exp_sel,
    output logic                               at_limit
);
    import plw_pkg::*;

    logic [PLW_CNT_W:0] limit;

    // Limit is 2^exp minus one; next tick overflows
    always_comb begin
        limit    = (22'h1 << exp_sel) - 22'h1;
        at_limit = ({1'b0, count} == limit);
    end
endmodule // plw_overflow_cmp

// [plw_pkg.sv]
package plw_pkg;
    // Register addresses on the peripheral bus
    localparam logic [15:0] PLW_MODE_ADDR      = 16'hff98;
    localparam logic [15:0] PLW_SERVICE_ADDR   = 16'hff99;
    // Mode reset value, service read value and service key
    localparam logic [7:0]  PLW_MODE_RESET     = 8'h67;
    localparam logic [7:0]  PLW_SERVICE_READ   = 8'h9a;
    localparam logic [7:0]  PLW_SERVICE_KEY    = 8'hac;
    // Mode register field positions
    localparam int          PLW_CLK_SEL_HI_POS = 4;
    localparam int          PLW_CLK_SEL_LO_POS = 3;
    localparam int          PLW_INTERVAL_LSB   = 0;
    localparam logic [2:0]  PLW_FIXED_TOP      = 3'h3;
    // Reset cause flag position
    localparam int          PLW_RESET_FLAG_POS = 4;
    // Overflow exponents for interval code 0
    localparam int          PLW_RING_EXP_BASE  = 11;
    localparam int          PLW_XTAL_EXP_BASE  = 13;
    localparam int          PLW_CNT_W          = 21;

    typedef enum logic [1:0] {
        PLW_SRC_RING,
        PLW_SRC_XTAL,
        PLW_SRC_STOP
    } plw_src_t;

    // Register access from the CPU
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        bit_op;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } plw_bus_t;

    // Clock tick and gating conditions
    typedef struct packed {
        logic ring_tick;
        logic xtal_tick;
        logic xtal_stopped;
        logic standby;
        logic osc_settling;
        logic cpu_on_xtal;
        logic main_osc_off;
    } plw_clk_t;
endpackage

// [plw_props.sv]
`timescale 1ns/1ps
// Fault checks need the fixed option, where no mode masks them
module plw_props (
    input wire logic              clk,
    input wire logic              srst,
    input wire plw_pkg::plw_bus_t bus,
    input wire plw_pkg::plw_clk_t clk_in,
    input wire logic              ring_fixed_opt,
    input wire logic              clear_reset_flag,
    input wire logic [7:0]        rdata,
    input wire logic              cpu_wait,
    input wire logic              internal_reset,
    input wire logic              watchdog_reset_flag
);
    import plw_pkg::*;
    logic mw;
    logic sw;
    logic seen_q;
    // Write strobes per register
    assign mw = bus.wr && bus.addr == PLW_MODE_ADDR;
    assign sw = bus.wr && bus.addr == PLW_SERVICE_ADDR;
    // Mode byte already taken since reset
    always_ff @(posedge clk) seen_q <= srst ? 1'b0 : seen_q | (mw & ~bus.bit_op);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    property p_cause;
        $rose(internal_reset) |-> $past(bus.wr) || $past(clk_in.ring_tick) || $past(clk_in.xtal_tick);
    endproperty
    a_cause: assert property (p_cause) else $error("reset without cause");
    property p_flag; internal_reset && !clear_reset_flag |=> watchdog_reset_flag; endproperty
    a_flag: assert property (p_flag) else $error("flag not set");
    property p_mode_rst; $past(srst) && bus.rd && bus.addr == PLW_MODE_ADDR |=> rdata == PLW_MODE_RESET; endproperty
    a_mode_rst: assert property (p_mode_rst) else $error("mode reset value");
    property p_second; ring_fixed_opt && seen_q && mw && !bus.bit_op |=> internal_reset; endproperty
    a_second: assert property (p_second) else $error("second mode write");
    property p_wait; mw && !bus.bit_op |-> cpu_wait; endproperty
    a_wait: assert property (p_wait) else $error("no wait on mode write");
    property p_svc_bad; ring_fixed_opt && sw && bus.wdata != PLW_SERVICE_KEY |=> internal_reset; endproperty
    a_svc_bad: assert property (p_svc_bad) else $error("bad service byte");
    property p_bit; ring_fixed_opt && sw && bus.bit_op |=> internal_reset; endproperty
    a_bit: assert property (p_bit) else $error("bit access to service");
    property p_svc_rd; bus.rd && bus.addr == PLW_SERVICE_ADDR |=> rdata == PLW_SERVICE_READ; endproperty
    a_svc_rd: assert property (p_svc_rd) else $error("service read value");
endmodule // plw_props

bind program_loop_watchdog plw_props plw_props_u (.clk, .srst, .bus, .clk_in, .ring_fixed_opt,
    .clear_reset_flag, .rdata, .cpu_wait, .internal_reset, .watchdog_reset_flag);

// [plw_tick_sel.sv]
`timescale 1ns/1ps
// Picks the count enable for the selected source, with standby gating
module plw_tick_sel (
    input  wire plw_pkg::plw_src_t src,
    input  wire plw_pkg::plw_clk_t clk_in,
    output logic                   count_en
);
    import plw_pkg::*;

    // Counter only moves on an allowed tick, else holds its value
    always_comb begin
        case (src)
            PLW_SRC_RING: count_en = clk_in.ring_tick && !clk_in.standby &&
                                     !(clk_in.cpu_on_xtal && clk_in.main_osc_off);
            PLW_SRC_XTAL: count_en = clk_in.xtal_tick && !clk_in.standby &&
                                     !clk_in.xtal_stopped && !clk_in.osc_settling;
            default:      count_en = 1'b0;
        endcase
    end
endmodule // plw_tick_sel

// [program_loop_watchdog.sv]
`timescale 1ns/1ps
// Function
// - Counter overflow before service raises the internal reset.
// - Watchdog-caused reset sets reset-cause bit 4.
// - Clock select 00 ring, 01 crystal, 1x stopped.
// - Interval code picks 2^11..2^18 ring or 2^13..2^20 crystal cycles.
// - Mode register resets to 67h.
// - After reset count immediately on ring clock, 2^18 interval.
// - Fixed-oscillator option ignores clock select writes, stays on ring.
// - Fixed-oscillator option never lets the watchdog stop.
// - Crystal source gated when stopped, in standby, or settling.
// - Ring source gated in standby or when CPU runs on crystal with main oscillator stopped.
// - Only one mode write after reset; a second one resets unless the watchdog is stopped.
// - Mode bits 7..5 written as 011; written value ignored, always loaded as 011.
// - Mode write inserts a CPU wait cycle.
// - Writing ACh to service register clears and restarts counter.
// - Any other service byte raises the internal reset unless the watchdog is stopped.
// - Bit access to service register raises the internal reset unless the watchdog is stopped.
// - Service register reads 9Ah always.
// - Any mode write clears the counter.
// - Gated counting resumes holding the previous count.
module program_loop_watchdog (
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire plw_pkg::plw_bus_t   bus,
    input  wire plw_pkg::plw_clk_t   clk_in,
    input  wire logic                ring_fixed_opt,
    input  wire logic                clear_reset_flag,
    output logic [7:0]               rdata,
    output logic                     cpu_wait,
    output logic                     internal_reset,
    output logic                     watchdog_reset_flag
);
    import plw_pkg::*;

    logic [7:0]            mode_q;
    logic                  mode_written_q;
    logic                  fixed_q;
    logic                  fixed_seen_q;
    logic [PLW_CNT_W-1:0]  count_q;
    logic                  rst_req_q;
    logic                  flag_q;
    logic [7:0]            rdata_q;
    plw_src_t              src;
    logic                  count_en;
    logic                  at_limit;
    logic [4:0]            exp_sel;
    logic                  mode_wr;
    logic                  serv_wr;
    logic                  fault;

    assign mode_wr = bus.wr && bus.addr == PLW_MODE_ADDR;
    assign serv_wr = (bus.wr || bus.bit_op) && bus.addr == PLW_SERVICE_ADDR;

    // Option strap caught after release, constant thereafter
    always_ff @(posedge clk) begin
        if (srst) begin
            fixed_seen_q <= 1'b0;
            fixed_q      <= 1'b0;
        end else if (!fixed_seen_q) begin
            fixed_seen_q <= 1'b1;
            fixed_q      <= ring_fixed_opt;
        end
    end

    // Effective option: live strap in the first cycle so no stop slips through
    logic fixed_eff;
    assign fixed_eff = fixed_seen_q ? fixed_q : ring_fixed_opt;

    // Source decode
    always_comb begin
        if (fixed_eff) begin
            src = PLW_SRC_RING;
        end else if (mode_q[PLW_CLK_SEL_HI_POS]) begin
            src = PLW_SRC_STOP;
        end else if (mode_q[PLW_CLK_SEL_LO_POS]) begin
            src = PLW_SRC_XTAL;
        end else begin
            src = PLW_SRC_RING;
        end
    end

    // Overflow exponent from interval code and source
    assign exp_sel = 5'(mode_q[PLW_INTERVAL_LSB +: 3]) +
                     ((src == PLW_SRC_XTAL) ? 5'(PLW_XTAL_EXP_BASE) : 5'(PLW_RING_EXP_BASE));

    plw_tick_sel u_tick_sel (
        .src      (src),
        .clk_in   (clk_in),
        .count_en (count_en)
    );

    plw_overflow_cmp u_overflow_cmp (
        .count    (count_q),
        .exp_sel  (exp_sel),
        .at_limit (at_limit)
    );

    // Faults are ignored while software has stopped the watchdog
    always_comb begin
        fault = 1'b0;
        if (src != PLW_SRC_STOP) begin
            if (mode_wr && mode_written_q) begin
                fault = 1'b1;
            end
            if (serv_wr && bus.bit_op) begin
                fault = 1'b1;
            end else if (serv_wr && bus.wdata != PLW_SERVICE_KEY) begin
                fault = 1'b1;
            end
            if (count_en && at_limit) begin
                fault = 1'b1;
            end
        end
    end

    // Mode register: one byte write after reset
    always_ff @(posedge clk) begin
        if (srst) begin
            mode_q         <= PLW_MODE_RESET;
            mode_written_q <= 1'b0;
        end else if (mode_wr && !bus.bit_op && !mode_written_q) begin
            mode_written_q <= 1'b1;
            if (fixed_eff) begin
                // Clock select and top bits keep their reset value
                mode_q <= {PLW_FIXED_TOP, PLW_MODE_RESET[4:3], bus.wdata[2:0]};
            end else begin
                mode_q <= {PLW_FIXED_TOP, bus.wdata[4:0]};
            end
        end
    end

    // Counter holds across gating so standby resumes where it left
    always_ff @(posedge clk) begin
        if (srst) begin
            count_q <= '0;
        end else if (mode_wr || (serv_wr && !bus.bit_op && bus.wdata == PLW_SERVICE_KEY)) begin
            count_q <= '0;
        end else if (count_en) begin
            count_q <= count_q + 1'b1;
        end
    end

    // Internal reset pulse; system reset is expected to follow on srst
    always_ff @(posedge clk) begin
        if (srst) begin
            rst_req_q <= 1'b0;
        end else begin
            rst_req_q <= fault;
        end
    end
    assign internal_reset = rst_req_q;

    // Cause flag survives srst; set wins over clear
    always_ff @(posedge clk) begin
        if (rst_req_q) begin
            flag_q <= 1'b1;
        end else if (clear_reset_flag) begin
            flag_q <= 1'b0;
        end
    end
    assign watchdog_reset_flag = flag_q;

    // Read data registered; service register always reads fixed value
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                PLW_MODE_ADDR:    rdata_q <= mode_q;
                PLW_SERVICE_ADDR: rdata_q <= PLW_SERVICE_READ;
                default:          rdata_q <= 8'h00;
            endcase
        end
    end
    assign rdata = rdata_q;

    // One wait cycle on any mode write
    assign cpu_wait = mode_wr;
endmodule // program_loop_watchdog

// [program_loop_watchdog_tb.sv]
`timescale 1ns/1ps
module program_loop_watchdog_tb;
    import plw_pkg::*;
    logic        clk, srst, ring_fixed_opt, clear_reset_flag, cpu_wait, internal_reset, watchdog_reset_flag;
    logic        rd_p, rs_p;
    logic [7:0]  rdata;
    logic [8:0]  q[$];
    logic [31:0] s = 32'hbf6a;
    int          miscompares, n_tests, cyc;
    plw_bus_t    bus;
    plw_clk_t    clk_in;

    program_loop_watchdog dut_u (.clk, .srst, .bus, .clk_in, .ring_fixed_opt, .clear_reset_flag,
        .rdata, .cpu_wait, .internal_reset, .watchdog_reset_flag);

    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end

    function logic [31:0] rnd();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task tally_and_finish();
        if (miscompares == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Delayed strobes time the checks; hang guard
    always @(posedge clk) begin
        rd_p <= bus.rd;
        rs_p <= internal_reset;
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    // Any reset with no note pending is a mismatch
    always @(negedge clk) begin
        logic [8:0] e;
        if (rd_p) begin
            e = q.pop_front();
            chk("rdata", rdata, e[7:0]);
        end
        if (internal_reset === 1'b1) begin
            e = q.size() ? q.pop_front() : 9'h0;
            chk("reset", 8'h1, {7'h0, e[8]});
        end
        if (rs_p) chk("flag", {7'h0, watchdog_reset_flag}, 8'h1);
    end

    // One access, then an idle cycle
    task acc(input logic w, input logic b, input logic [15:0] a, input logic [7:0] d);
        bus = '{w, ~w, b, a, d};
        @(negedge clk);
        bus = '0;
        @(negedge clk);
    endtask

    // Counted on rising edges so a time-zero clock event cannot shorten the hold
    task rs();
        srst = 1;
        clear_reset_flag = 1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        srst = 0;
        clear_reset_flag = 0;
    endtask

    // Random gated cycles must hold the count
    task run(input int n, input logic xt, input logic exp);
        int c;
        logic [31:0] r;
        logic g;
        c = 0;
        while (c < n) begin
            r = rnd();
            g = r[1:0] == 2'h0;
            if (xt)
                clk_in = {r[6], 1'b1, g ? 3'h1 << (r[3:2] % 3) : 3'h0, 2'h0};
            else
                clk_in = {1'b1, r[6], g ? (r[2] ? 5'h08 : 5'h03) : {r[5], 1'b0, r[4], 2'h0}};
            c += !g;
            if (exp && c == n) q.push_back(9'h100);
            @(negedge clk);
        end
        clk_in = '0;
        repeat (3) @(negedge clk);
    endtask

    initial begin
        bus = '0;
        clk_in = '0;
        ring_fixed_opt = 0;
        rs();
        q.push_back({1'b0, PLW_MODE_RESET});
        acc(0, 0, PLW_MODE_ADDR, 8'h0);
        for (int k = 0; k < 3; k++) begin
            rs();
            acc(1, 0, PLW_MODE_ADDR, {5'h0c, k[2:0]});
            run(1000, 0, 0);
            acc(1, 0, PLW_SERVICE_ADDR, PLW_SERVICE_KEY);
            q.push_back({1'b0, PLW_SERVICE_READ});
            acc(0, 0, PLW_SERVICE_ADDR, 8'h0);
            run(1 << (PLW_RING_EXP_BASE + k), 0, 1);
        end
        rs();
        acc(1, 0, PLW_MODE_ADDR, 8'h68);
        run(1 << PLW_XTAL_EXP_BASE, 1, 1);
        // Stopped: neither faults nor ticks reset
        rs();
        acc(1, 0, PLW_MODE_ADDR, 8'h70);
        acc(1, 0, PLW_SERVICE_ADDR, 8'h55);
        run(4096, 0, 0);
        ring_fixed_opt = 1;
        rs();
        acc(1, 0, PLW_MODE_ADDR, 8'hb8);
        run(1 << PLW_RING_EXP_BASE, 0, 1);
        for (int f = 0; f < 3; f++) begin
            rs();
            if (f == 2) acc(1, 0, PLW_MODE_ADDR, 8'h67);
            q.push_back(9'h100);
            acc(1, f == 1, f == 2 ? PLW_MODE_ADDR : PLW_SERVICE_ADDR, f == 1 ? PLW_SERVICE_KEY : 8'h55);
            repeat (2) @(negedge clk);
        end
        chk("pending", 8'(q.size()), 8'h0);
        tally_and_finish();
    end
endmodule // program_loop_watchdog_tb
